// ==== core/fws_flash_seq.sv ====
// Flash write/erase sequencer: latch buffer, command engine, lock bits.
// Assumes a flash array on clk taking one request, pulsing arr_done.
`timescale 1ns/1ns
// Summary of operation
// - Erase by 8 KB block, 128 KB sector, 512-byte pages, whole chip
// - User signature page has own erase/write/read modes; erase pin spares it
// - Page erase, ERASE_WRITE_PAGE_CMD and ERASE_WRITE_LOCK_PAGE_CMD only accepted inside the small 8 KB sectors
// - Descriptor words: id, size, page, planes, plane sizes, lock count, regions
// - A set lock bit refuses write and erase commands in its region; the erase pin clears all lock bits
// - Programming only clears bits, so pages are erased before programming
// - ERASE_WRITE_PAGE_CMD and ERASE_WRITE_LOCK_PAGE_CMD erase the page automatically before programming
// - WRITE_LOCK_PAGE_CMD and ERASE_WRITE_LOCK_PAGE_CMD set the covering lock bit after programming
// - Latch buffer is mirrored over the whole flash address range
// - Latch writes take the configured flash read wait states
// - Latch buffer is refilled with ones after each programming command
// - Buffer filled first; accepting a command clears the ready flag
// - Commands erase a whole plane or a run of pages one longer than the given count
// - A command returns the organization descriptor
module fws_flash_seq #(
  parameter logic [31:0] DESC_ID = 32'h0000_0001 // Arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [19:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  output logic [31:0] mem_rdata,
  output logic mem_ready,
  output logic mem_err,
  output logic [17:0] rd_waddr,
  output logic rd_user,
  input wire logic [31:0] arr_rdata,
  output fws_pkg::fws_arr_req_t arr_req,
  input wire logic arr_done,
  input wire logic erase_pin,
  output logic irq
);
  typedef enum {S_IDLE, S_ERASE, S_WAIT_E, S_PROG, S_WAIT_P, S_LOCK, S_FILL, S_FIN} fws_st_t;
  fws_st_t st_ff, nxt_st;
  logic [3:0] sts_ff, nxt_sts, mask_ff, nxt_mask, ws_ff, nxt_ws;
  logic [127:0] lock_ff, nxt_lock;
  logic [10:0] pg_ff, nxt_pg;
  logic [7:0] cnt_ff, nxt_cnt, didx_ff, nxt_didx;
  logic [6:0] widx_ff, nxt_widx;
  logic prog_ff, nxt_prog, dolk_ff, nxt_dolk, user_ff, nxt_user, umode_ff, nxt_umode;
  fws_pkg::fws_op_t eop_ff, nxt_eop;
  fws_pkg::fws_arr_req_t req_ff, nxt_req;
  logic [31:0] rdata_ff, nxt_rdata;
  logic ep1_ff, ep2_ff, ep3_ff;
  logic [31:0] lbuf [0:127];
  logic acc_ff, nxt_acc, awe_ff, nxt_awe, abad_ff, nxt_abad;
  logic [19:0] aaddr_ff, nxt_aaddr;
  logic [31:0] adata_ff, nxt_adata, mrd_ff, nxt_mrd;
  logic [3:0] wsc_ff, nxt_wsc;
  logic cmd_acc, acc_fin;
  logic [7:0] cmd;
  logic [10:0] cpg;

  function automatic logic any_lock(input logic [127:0] l, input logic [6:0] r0,
                                    input logic [7:0] nr);
    any_lock = 1'b0;
    for (int i = 0; i < 128; i++)
    begin
      if (i >= int'(r0) && i < int'(r0) + int'(nr) && l[i])
        any_lock = 1'b1;
    end
  endfunction

  function automatic logic [31:0] desc_word(input logic [7:0] i);
    case (i)
      8'h00: desc_word = DESC_ID;
      8'h01: desc_word = fws_pkg::FL_BYTES;
      8'h02: desc_word = fws_pkg::PG_BYTES;
      8'h03: desc_word = fws_pkg::PLANES;
      8'h04: desc_word = fws_pkg::FL_BYTES;
      8'h05: desc_word = fws_pkg::LK_COUNT;
      default: desc_word = (i < 8'h86) ? fws_pkg::LK_BYTES : 32'h0;
    endcase
  endfunction

  assign cmd = reg_wdata[7:0];
  assign cpg = reg_wdata[18:8];
  assign cmd_acc = reg_wr && reg_addr == fws_pkg::OFS_CMD && sts_ff[fws_pkg::ST_RDY];
  // latch writes use read wait states
  assign acc_fin = acc_ff && wsc_ff == ws_ff && sts_ff[fws_pkg::ST_RDY];
  assign irq = |(sts_ff & mask_ff & fws_pkg::STICKY);
  assign reg_rdata = rdata_ff;
  assign mem_rdata = mrd_ff;
  assign mem_ready = acc_fin;
  assign mem_err = acc_fin && abad_ff;
  assign rd_waddr = aaddr_ff[19:2];
  assign rd_user = umode_ff;
  assign arr_req = req_ff;

  always_comb
  begin
    logic [3:0] set;
    set = 4'h0;
    nxt_st = st_ff;
    nxt_mask = mask_ff;
    nxt_ws = ws_ff;
    nxt_lock = lock_ff;
    nxt_pg = pg_ff;
    nxt_cnt = cnt_ff;
    nxt_didx = didx_ff;
    nxt_widx = widx_ff;
    nxt_prog = prog_ff;
    nxt_dolk = dolk_ff;
    nxt_user = user_ff;
    nxt_umode = umode_ff;
    nxt_eop = eop_ff;
    nxt_req = '0;
    nxt_rdata = 32'h0;
    nxt_sts = sts_ff;
    if (reg_wr && reg_addr == fws_pkg::OFS_MODE)
      nxt_ws = reg_wdata[3:0];
    if (reg_wr && reg_addr == fws_pkg::OFS_MASK)
      nxt_mask = reg_wdata[3:0] & fws_pkg::STICKY;
    if (reg_wr && reg_addr == fws_pkg::OFS_STAT)
      nxt_sts = sts_ff & ~(reg_wdata[3:0] & fws_pkg::STICKY);
    if (reg_rd)
    begin
      case (reg_addr)
        fws_pkg::OFS_MODE: nxt_rdata = {28'h0, ws_ff};
        fws_pkg::OFS_STAT: nxt_rdata = {28'h0, sts_ff};
        fws_pkg::OFS_MASK: nxt_rdata = {28'h0, mask_ff};
        fws_pkg::OFS_RES:
        begin
          nxt_rdata = desc_word(didx_ff);
          nxt_didx = didx_ff + 8'h01;
        end
        default: nxt_rdata = 32'h0;
      endcase
    end
    case (st_ff)
      S_IDLE:
      begin
        nxt_prog = 1'b0;
        nxt_dolk = 1'b0;
        nxt_user = 1'b0;
        nxt_cnt = 8'h0;
        nxt_pg = cpg;
        // erase pin: chip erase, user page kept
        if (ep2_ff && !ep3_ff && sts_ff[fws_pkg::ST_RDY])
        begin
          nxt_lock = '0;
          // Busy while the pin erase runs
          nxt_sts[fws_pkg::ST_RDY] = 1'b0;
          nxt_eop = fws_pkg::OP_ERASE_CHIP;
          nxt_st = S_ERASE;
        end
        else if (cmd_acc)
        begin
          nxt_st = S_FIN;
          case (cmd)
            fws_pkg::C_GETD: nxt_didx = 8'h0;
            fws_pkg::C_WP, fws_pkg::C_WPL, fws_pkg::C_EWP, fws_pkg::C_ERASE_WRITE_LOCK_PAGE_CMD:
            begin
              nxt_dolk = cmd == fws_pkg::C_WPL || cmd == fws_pkg::C_ERASE_WRITE_LOCK_PAGE_CMD;
              nxt_eop = fws_pkg::OP_ERASE_PAGE;
              if (any_lock(lock_ff, cpg[10:4], 8'h01))
                set[fws_pkg::ST_LERR] = 1'b1;
              // page erase only in small sectors
              else if (cmd >= fws_pkg::C_EWP && cpg >= fws_pkg::SMALL_PAGES)
                set[fws_pkg::ST_CERR] = 1'b1;
              else if (cmd >= fws_pkg::C_EWP)
              begin
                nxt_prog = 1'b1;
                nxt_st = S_ERASE;
              end
              else
                nxt_st = S_PROG;
            end
            fws_pkg::C_EPA:
            begin
              nxt_eop = fws_pkg::OP_ERASE_PAGE;
              nxt_cnt = reg_wdata[31:24];
              if ({1'b0, cpg} + {4'h0, reg_wdata[31:24]} >= {1'b0, fws_pkg::SMALL_PAGES})
                set[fws_pkg::ST_CERR] = 1'b1;
              else if (any_lock(lock_ff, cpg[10:4], 8'h02))
                set[fws_pkg::ST_LERR] = 1'b1;
              else
                nxt_st = S_ERASE;
            end
            fws_pkg::C_EB:
            begin
              nxt_eop = fws_pkg::OP_ERASE_BLOCK;
              nxt_pg = {cpg[10:4], 4'h0};
              if (any_lock(lock_ff, cpg[10:4], 8'h01))
                set[fws_pkg::ST_LERR] = 1'b1;
              else
                nxt_st = S_ERASE;
            end
            fws_pkg::C_ES:
            begin
              nxt_eop = fws_pkg::OP_ERASE_SECTOR;
              nxt_pg = {cpg[10:8], 8'h0};
              if (any_lock(lock_ff, {cpg[10:8], 4'h0}, fws_pkg::SECT_REGIONS))
                set[fws_pkg::ST_LERR] = 1'b1;
              else
                nxt_st = S_ERASE;
            end
            fws_pkg::C_EA, fws_pkg::C_EPL:
            begin
              nxt_eop = fws_pkg::OP_ERASE_CHIP;
              if (|lock_ff)
                set[fws_pkg::ST_LERR] = 1'b1;
              else
                nxt_st = S_ERASE;
            end
            fws_pkg::C_SLB: nxt_lock[cpg[10:4]] = 1'b1;
            fws_pkg::C_CLB: nxt_lock[cpg[10:4]] = 1'b0;
            fws_pkg::C_WUS:
            begin
              nxt_user = 1'b1;
              nxt_st = S_PROG;
            end
            fws_pkg::C_EUS:
            begin
              nxt_eop = fws_pkg::OP_ERASE_USER;
              nxt_st = S_ERASE;
            end
            fws_pkg::C_STUS: nxt_umode = 1'b1;
            fws_pkg::C_SPUS: nxt_umode = 1'b0;
            default: set[fws_pkg::ST_CERR] = 1'b1;
          endcase
        end
      end
      S_ERASE:
      begin
        nxt_req = {1'b1, eop_ff, pg_ff, 7'h0, 32'h0};
        nxt_st = S_WAIT_E;
      end
      S_WAIT_E:
        if (arr_done)
        begin
          nxt_pg = pg_ff + 11'h1;
          nxt_cnt = cnt_ff - 8'h1;
          nxt_st = (cnt_ff != 8'h0) ? S_ERASE : (prog_ff ? S_PROG : S_FIN);
          if (cnt_ff == 8'h0)
            nxt_pg = pg_ff;
        end
      S_PROG:
      begin
        nxt_req.valid = 1'b1;
        nxt_req.op = user_ff ? fws_pkg::OP_PROG_USER : fws_pkg::OP_PROG;
        nxt_req.waddr = {pg_ff, widx_ff};
        nxt_req.data = lbuf[widx_ff];
        nxt_st = S_WAIT_P;
      end
      S_WAIT_P:
        if (arr_done)
        begin
          nxt_widx = widx_ff + 7'h1;
          if (widx_ff != fws_pkg::LAST_WORD)
            nxt_st = S_PROG;
          else
            nxt_st = dolk_ff ? S_LOCK : S_FILL;
        end
      S_LOCK:
      begin
        nxt_lock[pg_ff[10:4]] = 1'b1;
        nxt_st = S_FILL;
      end
      S_FILL: nxt_st = S_FIN;
      S_FIN:
      begin
        set[fws_pkg::ST_DONE] = 1'b1;
        set[fws_pkg::ST_RDY] = 1'b1;
        nxt_st = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
    if (cmd_acc)
      nxt_sts[fws_pkg::ST_RDY] = 1'b0;
    nxt_sts = nxt_sts | set;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= S_IDLE;
      sts_ff <= fws_pkg::STAT_RST;
      mask_ff <= 4'h0;
      ws_ff <= fws_pkg::WS_RST;
      lock_ff <= '0;
      pg_ff <= 11'h0;
      cnt_ff <= 8'h0;
      didx_ff <= 8'h0;
      widx_ff <= 7'h0;
      prog_ff <= 1'b0;
      dolk_ff <= 1'b0;
      user_ff <= 1'b0;
      umode_ff <= 1'b0;
      eop_ff <= fws_pkg::OP_PROG;
      req_ff <= '0;
      rdata_ff <= 32'h0;
      ep1_ff <= 1'b0;
      ep2_ff <= 1'b0;
      ep3_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      sts_ff <= nxt_sts;
      mask_ff <= nxt_mask;
      ws_ff <= nxt_ws;
      lock_ff <= nxt_lock;
      pg_ff <= nxt_pg;
      cnt_ff <= nxt_cnt;
      didx_ff <= nxt_didx;
      widx_ff <= nxt_widx;
      prog_ff <= nxt_prog;
      dolk_ff <= nxt_dolk;
      user_ff <= nxt_user;
      umode_ff <= nxt_umode;
      eop_ff <= nxt_eop;
      req_ff <= nxt_req;
      rdata_ff <= nxt_rdata;
      ep1_ff <= erase_pin;
      ep2_ff <= ep1_ff;
      ep3_ff <= ep2_ff;
    end
  end

  // Bus access: held until idle and wait states spent
  always_comb
  begin
    nxt_acc = acc_ff;
    nxt_awe = awe_ff;
    nxt_abad = abad_ff;
    nxt_aaddr = aaddr_ff;
    nxt_adata = adata_ff;
    nxt_mrd = mrd_ff;
    nxt_wsc = (acc_ff && wsc_ff != ws_ff) ? wsc_ff + 4'h1 : wsc_ff;
    if (acc_fin)
    begin
      nxt_acc = 1'b0;
      if (!awe_ff)
        nxt_mrd = arr_rdata;
    end
    else if (!acc_ff && (mem_wr || mem_rd))
    begin
      nxt_acc = 1'b1;
      nxt_awe = mem_wr;
      nxt_aaddr = mem_addr;
      nxt_adata = mem_wdata;
      nxt_wsc = 4'h0;
      nxt_abad = mem_size != 2'h2 || mem_addr[1:0] != 2'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_ff <= 1'b0;
      awe_ff <= 1'b0;
      abad_ff <= 1'b0;
      aaddr_ff <= 20'h0;
      adata_ff <= 32'h0;
      mrd_ff <= 32'h0;
      wsc_ff <= 4'h0;
    end
    else
    begin
      acc_ff <= nxt_acc;
      awe_ff <= nxt_awe;
      abad_ff <= nxt_abad;
      aaddr_ff <= nxt_aaddr;
      adata_ff <= nxt_adata;
      mrd_ff <= nxt_mrd;
      wsc_ff <= nxt_wsc;
    end
  end

  // Latch buffer memory
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 128; i++)
        lbuf[i] <= fws_pkg::ONES;
    end
    else if (st_ff == S_FILL)
    begin
      for (int i = 0; i < 128; i++)
        lbuf[i] <= fws_pkg::ONES;
    end
    else if (acc_fin && awe_ff && !abad_ff)
      lbuf[aaddr_ff[8:2]] <= adata_ff;
  end

  sequence s_ewp_go;
    cmd_acc && cmd == fws_pkg::C_EWP && cpg < fws_pkg::SMALL_PAGES
      && !any_lock(lock_ff, cpg[10:4], 8'h01) && st_ff == S_IDLE && !(ep2_ff && !ep3_ff);
  endsequence
  sequence s_erase_issue;
    st_ff == S_ERASE ##1 req_ff.valid && req_ff.op == fws_pkg::OP_ERASE_PAGE;
  endsequence
  a_ewp_erase_first: assert property (@(posedge clk) disable iff (!reset_n)
    s_ewp_go |=> s_erase_issue) else $error("erase not issued before program");
  a_cmd_drop_rdy: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_acc |=> !sts_ff[fws_pkg::ST_RDY]) else $error("ready not cleared");
  a_fin_sets_rdy: assert property (@(posedge clk) disable iff (!reset_n)
    st_ff == S_FIN |=> sts_ff[fws_pkg::ST_RDY] && st_ff == S_IDLE) else $error("ready not set");
  a_fill_all_ones: assert property (@(posedge clk) disable iff (!reset_n)
    st_ff == S_FILL |=> lbuf[0] == fws_pkg::ONES && lbuf[127] == fws_pkg::ONES)
    else $error("buffer not refilled");
  a_page_small: assert property (@(posedge clk) disable iff (!reset_n)
    req_ff.valid && req_ff.op == fws_pkg::OP_ERASE_PAGE |-> req_ff.waddr[17:7] < fws_pkg::SMALL_PAGES)
    else $error("page erase outside small sectors");
  a_lock_guard: assert property (@(posedge clk) disable iff (!reset_n)
    req_ff.valid && (req_ff.op == fws_pkg::OP_PROG || req_ff.op == fws_pkg::OP_ERASE_PAGE)
    |-> !lock_ff[req_ff.waddr[17:11]]) else $error("locked region touched");
  a_lock_after: assert property (@(posedge clk) disable iff (!reset_n)
    st_ff == S_LOCK |=> lock_ff[pg_ff[10:4]] ##1 st_ff == S_FIN) else $error("lock not set");
  a_ws_count: assert property (@(posedge clk) disable iff (!reset_n)
    !acc_ff && mem_wr && ws_ff == 4'h2 && st_ff == S_IDLE && !cmd_acc && !(ep2_ff && !ep3_ff)
    |-> !mem_ready [*3] ##1 mem_ready) else $error("wait states wrong");
  a_wrap_store: assert property (@(posedge clk) disable iff (!reset_n)
    mem_ready && awe_ff && !abad_ff |=> lbuf[$past(aaddr_ff[8:2])] == $past(adata_ff))
    else $error("latch word not stored");
  a_desc_page: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == fws_pkg::OFS_RES && didx_ff == 8'h02 |=> reg_rdata == fws_pkg::PG_BYTES)
    else $error("descriptor word wrong");
endmodule // fws_flash_seq

// ==== core/fws_pkg.sv ====
// Package: map, commands, sizes and carrier types of the flash sequencer.
// Assumes one 50 MHz system clock shared with the flash array logic.
package fws_pkg;
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_CMD = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_RES = 4'hc;
  localparam logic [3:0] OFS_MASK = 4'h2;
  localparam int ST_RDY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_CERR = 2;
  localparam int ST_LERR = 3;
  localparam logic [3:0] STICKY = 4'he;
  localparam logic [3:0] STAT_RST = 4'h1;
  localparam logic [3:0] WS_RST = 4'h0;
  localparam logic [7:0] C_GETD = 8'h00;
  localparam logic [7:0] C_WP = 8'h01;
  localparam logic [7:0] C_WPL = 8'h02;
  localparam logic [7:0] C_EWP = 8'h03;
  localparam logic [7:0] C_ERASE_WRITE_LOCK_PAGE_CMD = 8'h04;
  localparam logic [7:0] C_EA = 8'h05;
  localparam logic [7:0] C_EPL = 8'h06;
  localparam logic [7:0] C_EPA = 8'h07;
  localparam logic [7:0] C_EB = 8'h08;
  localparam logic [7:0] C_ES = 8'h09;
  localparam logic [7:0] C_SLB = 8'h0a;
  localparam logic [7:0] C_CLB = 8'h0b;
  localparam logic [7:0] C_WUS = 8'h0c;
  localparam logic [7:0] C_EUS = 8'h0d;
  localparam logic [7:0] C_STUS = 8'h0e;
  localparam logic [7:0] C_SPUS = 8'h0f;
  localparam logic [31:0] FL_BYTES = 32'h0010_0000;
  localparam logic [31:0] PG_BYTES = 32'h0000_0200;
  localparam logic [31:0] PLANES = 32'h0000_0001;
  localparam logic [31:0] LK_BYTES = 32'h0000_2000;
  localparam logic [31:0] LK_COUNT = 32'h0000_0080;
  localparam logic [10:0] SMALL_PAGES = 11'h020;
  localparam logic [7:0] SECT_REGIONS = 8'h10;
  localparam logic [6:0] LAST_WORD = 7'h7f;
  localparam logic [31:0] ONES = 32'hffff_ffff;
  typedef enum logic [3:0] {
    OP_PROG, OP_PROG_USER, OP_ERASE_PAGE, OP_ERASE_BLOCK,
    OP_ERASE_SECTOR, OP_ERASE_CHIP, OP_ERASE_USER
  } fws_op_t;
  typedef struct packed {
    logic valid;
    fws_op_t op;
    logic [17:0] waddr;
    logic [31:0] data;
  } fws_arr_req_t;
endpackage

// ==== testbench/fws_array_model.sv ====
// Flash array model: word store, programming clears bits, erase by range.
// Assumes one request at a time, the next one only after arr_done.
`timescale 1ns/1ns
module fws_array_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [17:0] rd_waddr,
  input wire logic rd_user,
  output logic [31:0] arr_rdata,
  input wire fws_pkg::fws_arr_req_t arr_req,
  output logic arr_done
);
  logic [31:0] mem[0:262143];
  logic [31:0] usr[0:127];
  int n;
  int b;
  initial
  begin
    foreach (mem[i])
      mem[i] = fws_pkg::ONES;
    foreach (usr[i])
      usr[i] = fws_pkg::ONES;
  end
  assign arr_rdata = rd_user ? usr[rd_waddr[6:0]] : mem[rd_waddr];
  always @(posedge clk)
  begin
    if (arr_req.valid === 1'b1)
    begin
      case (arr_req.op)
        fws_pkg::OP_ERASE_PAGE: n = 128;
        fws_pkg::OP_ERASE_BLOCK: n = 2048;
        fws_pkg::OP_ERASE_SECTOR: n = 32768;
        fws_pkg::OP_ERASE_CHIP: n = 262144;
        default: n = 0;
      endcase
      b = int'(arr_req.waddr) & ~(n - 1);
      for (int i = 0; i < n; i++)
        mem[b + i] = fws_pkg::ONES;
      // User page only by own ops
      if (arr_req.op == fws_pkg::OP_ERASE_USER)
        foreach (usr[i])
          usr[i] = fws_pkg::ONES;
      if (arr_req.op == fws_pkg::OP_PROG_USER)
        usr[arr_req.waddr[6:0]] &= arr_req.data;
      if (arr_req.op == fws_pkg::OP_PROG)
        mem[arr_req.waddr] &= arr_req.data;
      repeat (slow ? 6 : 1) @(posedge clk);
      arr_done <= 1'b1;
      @(posedge clk);
      arr_done <= 1'b0;
    end
    else
      arr_done <= 1'b0;
  end
endmodule // fws_array_model

// ==== testbench/tb.sv ====
// Testbench: register bus, latch buffer writes, commands, array model.
// Assumes the sequencer and array model share the 50 MHz clock.
`timescale 1ns/1ns
module tb;
  // Two wait states so the latency assertion is exercised
  localparam logic [3:0] WS = 4'h2;
  localparam logic [31:0] DID = 32'h0000_5a5a; // Arbitrary value
  localparam logic [31:0] DESC[7] = '{DID, fws_pkg::FL_BYTES, fws_pkg::PG_BYTES,
    fws_pkg::PLANES, fws_pkg::FL_BYTES / fws_pkg::PLANES, fws_pkg::LK_COUNT, fws_pkg::LK_BYTES};
  localparam logic [7:0] CMDS[12] = '{fws_pkg::C_CLB, fws_pkg::C_WPL, fws_pkg::C_SLB,
    fws_pkg::C_CLB, fws_pkg::C_ES, fws_pkg::C_EPL, fws_pkg::C_EA, fws_pkg::C_EPA,
    fws_pkg::C_WUS, fws_pkg::C_EUS, fws_pkg::C_STUS, fws_pkg::C_SPUS};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [19:0] mem_addr = 20'h0;
  logic [1:0] mem_size = 2'h2;
  logic [31:0] mem_wdata = 32'h0;
  logic mem_wr = 1'b0;
  logic mem_rd = 1'b0;
  logic [31:0] mem_rdata;
  logic mem_ready;
  logic mem_err;
  logic [17:0] rd_waddr;
  logic rd_user;
  logic [31:0] arr_rdata;
  fws_pkg::fws_arr_req_t arr_req;
  logic arr_done;
  logic erase_pin = 1'b0;
  logic irq;
  logic slow = 1'b0;
  logic rd_d = 1'b0;
  logic mr_d = 1'b0;
  int err_total = 0;
  int n_compared = 0;
  int seed = 97694;
  int n;
  logic [63:0] reg_q[$];
  logic [33:0] mem_q[$];
  logic [31:0] img[0:127];
  logic [31:0] keep[0:127];

  always #10 clk = ~clk;

  fws_flash_seq #(.DESC_ID(DID)) dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_ready(mem_ready), .mem_err(mem_err),
    .rd_waddr(rd_waddr), .rd_user(rd_user), .arr_rdata(arr_rdata), .arr_req(arr_req),
    .arr_done(arr_done), .erase_pin(erase_pin), .irq(irq));

  fws_array_model u_arr (.clk(clk), .slow(slow), .rd_waddr(rd_waddr), .rd_user(rd_user),
    .arr_rdata(arr_rdata), .arr_req(arr_req), .arr_done(arr_done));

  task automatic finish_test();
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s, e, m);
    n_compared++;
    if ((s & m) !== (e & m))
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e & m, s & m);
    end
  endtask

  // Takes the oldest note whenever a result appears
  always @(posedge clk)
  begin : mon
    logic [63:0] er;
    logic [33:0] em;
    if (rd_d)
    begin
      er = reg_q.pop_front();
      check("reg_rdata", reg_rdata, er[31:0], er[63:32]);
    end
    rd_d = reg_rd;
    // Read data stands from the edge that ends the ready cycle
    if (mr_d)
      check("mem_rdata", mem_rdata, em[31:0], {32{em[33]}});
    mr_d = mem_ready === 1'b1;
    if (mem_ready === 1'b1)
    begin
      em = mem_q.pop_front();
      check("mem_err", {31'h0, mem_err}, {31'h0, em[32]}, 32'h1);
    end
  end

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [31:0] e, m);
    reg_q.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Note entry is {check data, error, data}
  task automatic mem_acc(input logic wr, input logic [19:0] a, input logic [1:0] sz,
                         input logic [31:0] d, input logic [33:0] e, output int c);
    mem_q.push_back(e);
    mem_addr <= a;
    mem_size <= sz;
    mem_wdata <= d;
    mem_wr <= wr;
    mem_rd <= ~wr;
    @(posedge clk);
    mem_wr <= 1'b0;
    mem_rd <= 1'b0;
    c = 1;
    @(negedge clk);
    while (mem_ready !== 1'b1 && c < 200)
    begin
      @(negedge clk);
      c++;
    end
    @(posedge clk);
  endtask

  task automatic fill(input logic [10:0] pg, input logic down);
    int i;
    int c;
    for (int k = 0; k < 128; k++)
    begin
      i = down ? 127 - k : k;
      img[i] = $random(seed);
      mem_acc(1'b1, {pg, i[6:0], 2'h0}, 2'h2, img[i], 34'h0, c);
      check("latency", 32'(c), {28'h0, WS} + 32'h1, 32'hffffffff);
    end
  endtask

  // Mode 0 erased, 1 kept copy, 2 kept and latest, 3 latest
  task automatic read_page(input logic [10:0] pg, input int how);
    logic [31:0] e;
    int c;
    for (int i = 0; i < 128; i++)
    begin
      e = how == 0 ? fws_pkg::ONES : how == 1 ? keep[i] : how == 2 ? keep[i] & img[i] : img[i];
      mem_acc(1'b0, {pg, i[6:0], 2'h0}, 2'h2, 32'h0, {2'b10, e}, c);
    end
  endtask

  task automatic cmd_issue(input logic [7:0] c, input logic [10:0] pg);
    slow <= 1'($random(seed));
    reg_write(fws_pkg::OFS_CMD, {13'h0, pg, c});
  endtask

  task automatic cmd_wait(input logic [3:0] e, m);
    int c;
    c = 0;
    while (irq !== 1'b1 && c < 20000)
    begin
      @(posedge clk);
      c++;
    end
    reg_read(fws_pkg::OFS_STAT, {28'h0, e}, {28'h0, m});
    reg_write(fws_pkg::OFS_MASK, 32'h0);
    check("irq", {31'h0, irq}, 32'h0, 32'h1);
    reg_write(fws_pkg::OFS_MASK, {28'h0, fws_pkg::STICKY});
    check("irq", {31'h0, irq}, 32'h1, 32'h1);
    reg_write(fws_pkg::OFS_STAT, {28'h0, fws_pkg::STICKY});
    check("irq", {31'h0, irq}, 32'h0, 32'h1);
  endtask

  initial
  begin
    #(80000 * 20);
    err_total++;
    finish_test();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    reg_read(fws_pkg::OFS_STAT, {28'h0, fws_pkg::STAT_RST}, 32'hf);
    reg_read(fws_pkg::OFS_MODE, {28'h0, fws_pkg::WS_RST}, 32'hf);
    reg_read(4'h6, 32'h0, 32'hffffffff);
    reg_write(fws_pkg::OFS_MODE, {28'h0, WS});
    reg_write(fws_pkg::OFS_MASK, {28'h0, fws_pkg::STICKY});
    reg_read(fws_pkg::OFS_MODE, {28'h0, WS}, 32'hf);
    mem_acc(1'b1, 20'h00100, 2'h1, fws_pkg::ONES, {2'b01, 32'h0}, n);
    mem_acc(1'b1, 20'h00102, 2'h2, fws_pkg::ONES, {2'b01, 32'h0}, n);
    cmd_issue(fws_pkg::C_GETD, 11'h000);
    cmd_wait(4'h3, 4'hf);
    foreach (DESC[i])
      reg_read(fws_pkg::OFS_RES, DESC[i], 32'hffffffff);
    fill(11'h064, 1'b0);
    keep = img;
    cmd_issue(fws_pkg::C_WP, 11'h064);
    reg_read(fws_pkg::OFS_STAT, 32'h0, 32'h1);
    cmd_issue(fws_pkg::C_SLB, 11'h064);
    cmd_wait(4'h3, 4'hf);
    cmd_issue(fws_pkg::C_WP, 11'h065);
    cmd_wait(4'h3, 4'hf);
    read_page(11'h065, 0);
    read_page(11'h064, 1);
    fill(11'h003, 1'b1);
    cmd_issue(fws_pkg::C_WP, 11'h064);
    cmd_wait(4'h3, 4'hf);
    read_page(11'h064, 2);
    cmd_issue(fws_pkg::C_EB, 11'h064);
    cmd_wait(4'h3, 4'hf);
    read_page(11'h064, 0);
    fill(11'h003, 1'b0);
    cmd_issue(fws_pkg::C_WP, 11'h003);
    cmd_wait(4'h3, 4'hf);
    fill(11'h003, 1'b0);
    cmd_issue(fws_pkg::C_EWP, 11'h003);
    cmd_wait(4'h3, 4'hf);
    read_page(11'h003, 3);
    cmd_issue(fws_pkg::C_EWP, 11'h064);
    cmd_wait(4'h5, 4'h5);
    fill(11'h004, 1'b0);
    keep = img;
    cmd_issue(fws_pkg::C_ERASE_WRITE_LOCK_PAGE_CMD, 11'h004);
    cmd_wait(4'h3, 4'hf);
    fill(11'h004, 1'b0);
    cmd_issue(fws_pkg::C_WP, 11'h004);
    cmd_wait(4'h9, 4'h9);
    read_page(11'h004, 1);
    foreach (CMDS[i])
    begin
      cmd_issue(CMDS[i], 11'h000);
      cmd_wait(4'h2, 4'h6);
    end
    // User page survives the erase pin
    fill(11'h000, 1'b0);
    keep = img;
    cmd_issue(fws_pkg::C_WUS, 11'h000);
    cmd_wait(4'h3, 4'hf);
    erase_pin <= 1'b1;
    repeat (4) @(posedge clk);
    erase_pin <= 1'b0;
    cmd_wait(4'h3, 4'hf);
    cmd_issue(fws_pkg::C_STUS, 11'h000);
    cmd_wait(4'h3, 4'hf);
    read_page(11'h000, 1);
    cmd_issue(fws_pkg::C_SPUS, 11'h000);
    cmd_wait(4'h3, 4'hf);
    read_page(11'h000, 0);
    finish_test();
  end
endmodule // tb
